// >>> abp_cfg.svh
// Purpose: constants of the audio bus port transport and banking block
// Assumes: 32-bit classic Wishbone, 8-bit register contents in the low bits
// Notes:   byte offsets, field positions and reset values
`ifndef ABP_CFG_SVH
`define ABP_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define ABP_NCH          2
`define ABP_SMPW         32
`define ABP_ALIAS_DEV    4'hF
`define ABP_DEV_RESET    4'h0

// ----------------------------------------------------------------
// command address layout (wishbone address bits)
// ----------------------------------------------------------------
`define ABP_SPACE_BIT    15
`define ABP_DEV_MSB      19
`define ABP_DEV_LSB      16

// ----------------------------------------------------------------
// local register byte offsets
// ----------------------------------------------------------------
`define ABP_FRAME_CTL0   8'h00
`define ABP_FRAME_CTL1   8'h04
`define ABP_DEV_NUM      8'h08
`define ABP_STATUS       8'h0C
`define ABP_ARM_CTL      8'h10
`define ABP_ARM_STAT     8'h14
`define ABP_BANK0_BASE   3'h1
`define ABP_BANK1_BASE   3'h2
`define ABP_B_RUN        5'h00
`define ABP_B_INTV_LO    5'h04
`define ABP_B_INTV_HI    5'h08
`define ABP_B_WINDOW     5'h0C
`define ABP_B_OFFSET     5'h10
`define ABP_B_WORDLEN    5'h14
`define ABP_B_PACK       5'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ABP_FC_RESET     8'h0F
`define ABP_INTV_RESET   16'h0040

`endif

// >>> abp_pkg.sv
// Purpose: types shared by the transport block and its slot mapper
// Assumes: abp_cfg.svh constants
// Notes:   one banked copy is abp_bank_t
`include "abp_cfg.svh"
package abp_pkg;
  typedef struct packed {
    logic [`ABP_NCH-1:0] run;
    logic [15:0]         interval;
    logic [3:0]          firstCol;
    logic [3:0]          lastCol;
    logic [7:0]          offset;
    logic [4:0]          wordLen;
    logic                packPort;
  } abp_bank_t;

  typedef struct packed {
    logic hit;
    logic bitVal;
  } abp_map_st_t;

  typedef struct packed {
    logic                          clkMeta;
    logic                          clkSync;
    logic                          clkPrev;
    abp_bank_t [1:0]               bank;
    logic [1:0][7:0]               frameCtl;
    logic                          activeBank;
    logic                          pendValid;
    logic                          pendBank;
    logic [3:0]                    devNum;
    logic [`ABP_NCH-1:0]           arm;
    logic [3:0]                    col;
    logic [15:0]                   intervalPos;
    logic [15:0]                   winIdx;
    logic                          slot;
    logic                          inWin;
    logic [`ABP_NCH*`ABP_SMPW-1:0] hold;
    logic                          ack;
    logic                          err;
    logic [31:0]                   datOut;
    logic                          pbReq;
    logic                          pbWe;
    logic [14:0]                   pbAddr;
    logic [7:0]                    pbWdata;
    logic                          linkOut;
    logic                          linkOe;
  } abp_top_st_t;
endpackage

// >>> abp_map_if.sv
// Purpose: carries active config, slot position and samples to the slot mapper, and its result back
// Assumes: one clock domain, core_clk
// Notes:   top drives the slot side, mapper drives the result
`timescale 1ns/100ps
`include "abp_cfg.svh"
interface abp_map_if;
  import abp_pkg::*;
  abp_bank_t                     cfg;
  logic                          slot;
  logic                          inWin;
  logic [15:0]                   winIdx;
  logic [`ABP_NCH*`ABP_SMPW-1:0] samples;
  abp_map_st_t                   res;
  modport top    (output cfg, output slot, output inWin, output winIdx, output samples,
                  input res);
  modport mapper (input cfg, input slot, input inWin, input winIdx, input samples,
                  output res);
endinterface

// >>> abp_slot_map.sv
// Purpose: decides whether a window slot carries one of our channel bits
// Assumes: winIdx counts window slots since the start of the sample interval
// Notes:   result holds from one slot pulse to the next
`timescale 1ns/100ps
`include "abp_cfg.svh"
module abp_slot_map (
  input wire logic clk,
  input wire logic rst_n,
  abp_map_if.mapper m
);
  import abp_pkg::*;

  // ----------------------------------------------------------------
  // per channel block placement
  // ----------------------------------------------------------------
  logic [5:0]           blockLen;
  logic [7:0]           rank [`ABP_NCH+1];
  logic [`ABP_NCH-1:0]  hitVec;
  logic [`ABP_NCH-1:0]  bitVec;
  abp_map_st_t          cur;
  abp_map_st_t          next_cur;

  assign blockLen = {1'b0, m.cfg.wordLen} + 6'h01;
  assign rank[0]  = 8'h00;

  genvar c;
  generate
    for (c = 0; c < `ABP_NCH; c++) begin : g_ch
      logic [15:0] start;
      logic [15:0] rel;
      logic [4:0]  bitIdx;
      assign rank[c+1] = rank[c] + {7'h00, m.cfg.run[c]};
      // per-port: enabled channels back to back; per-channel: own block, one slot apart
      assign start = m.cfg.packPort
                     ? 16'(m.cfg.offset) + 16'(rank[c]) * 16'(blockLen)
                     : 16'(m.cfg.offset) + 16'(c) * (16'(blockLen) + 16'h0001);
      assign rel    = m.winIdx - start;
      assign bitIdx = m.cfg.wordLen - rel[4:0];
      assign hitVec[c] = m.cfg.run[c] && (m.winIdx >= start)
                         && (rel < 16'(blockLen));
      assign bitVec[c] = m.samples[c*`ABP_SMPW + int'(bitIdx)];
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    if (m.slot) begin
      next_cur.hit    = m.inWin && (|hitVec);
      next_cur.bitVal = |(hitVec & bitVec);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign m.res = cur;
endmodule

// >>> abp_port_top.sv
// Purpose: slave data port transport, arm/run handshake, address split and banking
// Assumes: frameStart comes from the frame-sync logic on core_clk and marks slot [0,0]
// Notes:   wishbone adr[19:16] is the target device number, adr[15:0] the command address
`timescale 1ns/100ps
`include "abp_cfg.svh"

module abp_port_top (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic [19:0]                   wb_adr_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  input  wire logic                          linkClk,
  input  wire logic                          frameStart,
  output logic                               linkDataOut,
  output logic                               linkDataOe,
  input  wire logic [`ABP_NCH*`ABP_SMPW-1:0] chSamples,
  input  wire logic [`ABP_NCH-1:0]           chRunning,
  output logic                               pbReq,
  output logic                               pbWe,
  output logic      [14:0]                   pbAddr,
  output logic      [7:0]                    pbWdata,
  input  wire logic                          pbDone
);
  import abp_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  // the rest of the block leaves reset two edges after the pin
  assign rst_n = rstPipe[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  abp_top_st_t         cur;
  abp_top_st_t         next_cur;
  abp_map_if           mIf ();
  abp_bank_t           act;
  logic                req;
  logic                paged;
  logic [3:0]          devAddr;
  logic                forUs;
  logic                isAlias;
  logic [7:0]          reg8;
  logic                bankHit;
  logic                bankSel;
  logic [`ABP_NCH-1:0] ready;
  logic [`ABP_NCH-1:0] pending;
  logic                wrLo;
  logic                slotEdge;
  logic                colInWin;

  assign req      = wb_cyc_i && wb_stb_i && !cur.ack && !cur.err;
  assign paged    = wb_adr_i[`ABP_SPACE_BIT];
  assign devAddr  = wb_adr_i[`ABP_DEV_MSB:`ABP_DEV_LSB];
  assign isAlias  = devAddr == `ABP_ALIAS_DEV;
  assign forUs    = devAddr == cur.devNum;
  assign reg8     = wb_adr_i[7:0];
  assign bankHit  = (reg8[7:5] == `ABP_BANK0_BASE) || (reg8[7:5] == `ABP_BANK1_BASE);
  assign bankSel  = reg8[7:5] == `ABP_BANK1_BASE;
  assign wrLo     = wb_we_i && wb_sel_i[0];
  assign act      = cur.bank[cur.activeBank];
  assign ready    = cur.arm & chRunning;
  assign pending  = cur.arm & ~chRunning;
  assign slotEdge = cur.clkSync != cur.clkPrev;
  assign colInWin = (cur.col != 4'h0) && (cur.col >= act.firstCol)
                    && (cur.col <= act.lastCol);

  assign mIf.cfg     = act;
  assign mIf.slot    = cur.slot;
  assign mIf.inWin   = cur.inWin;
  assign mIf.winIdx  = cur.winIdx;
  assign mIf.samples = cur.hold;

  abp_slot_map u_map (
    .clk   (core_clk),
    .rst_n (rst_n),
    .m     (mIf.mapper)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur         = cur;
    next_cur.clkMeta = linkClk;
    next_cur.clkSync = cur.clkMeta;
    next_cur.clkPrev = cur.clkSync;
    next_cur.ack     = 1'b0;
    next_cur.err     = 1'b0;
    next_cur.slot    = 1'b0;

    // link: both clock edges advance one bit slot
    if (slotEdge) begin
      next_cur.slot  = 1'b1;
      next_cur.inWin = colInWin;
      if (frameStart) begin
        next_cur.col = 4'h0;
        if (cur.pendValid) begin
          // switch lands on the frame boundary, never mid frame
          next_cur.activeBank  = cur.pendBank;
          next_cur.pendValid   = 1'b0;
          next_cur.intervalPos = 16'h0000;
          next_cur.winIdx      = 16'h0000;
          next_cur.inWin       = 1'b0;
        end
      end else if (cur.col >= cur.frameCtl[cur.activeBank][3:0]) begin
        next_cur.col = 4'h0;
      end else begin
        next_cur.col = cur.col + 4'h1;
      end
      if (!(frameStart && cur.pendValid)) begin
        if (cur.intervalPos + 16'h0001 >= act.interval) begin
          next_cur.intervalPos = 16'h0000;
          next_cur.winIdx      = 16'h0000;
          next_cur.hold        = chSamples;
        end else begin
          next_cur.intervalPos = cur.intervalPos + 16'h0001;
          // count window slots already passed, so the first window slot is index 0
          if (cur.inWin) begin
            next_cur.winIdx = cur.winIdx + 16'h0001;
          end
        end
      end
    end

    // pin: isochronous bits only, driven only in our own slots
    next_cur.linkOut = mIf.res.bitVal;
    next_cur.linkOe  = mIf.res.hit;

    // peripheral bus bridge completion
    if (cur.pbReq && pbDone) begin
      next_cur.pbReq = 1'b0;
    end

    // register bus
    if (req) begin
      next_cur.datOut = 32'h0000_0000;
      if (paged) begin
        if (!forUs) begin
          next_cur.ack = 1'b1;
        end else if (cur.pbReq) begin
          next_cur.err = 1'b1;
        end else begin
          next_cur.ack     = 1'b1;
          next_cur.pbReq   = 1'b1;
          next_cur.pbWe    = wb_we_i;
          next_cur.pbAddr  = wb_adr_i[14:0];
          next_cur.pbWdata = wb_dat_i[7:0];
        end
      end else begin
        next_cur.ack = 1'b1;
        // slave_control_port registers sit below the data port
        if ((reg8 == `ABP_FRAME_CTL0 || reg8 == `ABP_FRAME_CTL1)
            && (forUs || isAlias)) begin
          if (wrLo) begin
            next_cur.frameCtl[reg8[2]] = wb_dat_i[7:0];
            next_cur.pendValid         = 1'b1;
            next_cur.pendBank          = reg8[2];
          end
          next_cur.datOut = {24'h0, cur.frameCtl[reg8[2]]};
        end else if (forUs) begin
          case (reg8)
            `ABP_DEV_NUM: begin
              if (wrLo) begin
                next_cur.devNum = wb_dat_i[3:0];
              end
              next_cur.datOut = {28'h0, cur.devNum};
            end
            `ABP_STATUS: begin
              next_cur.datOut = {28'h0, cur.pbReq, cur.pendBank, cur.pendValid,
                                 cur.activeBank};
            end
            `ABP_ARM_CTL: begin
              if (wrLo) begin
                next_cur.arm = wb_dat_i[`ABP_NCH-1:0];
              end
              next_cur.datOut = 32'(cur.arm);
            end
            `ABP_ARM_STAT: begin
              next_cur.datOut = 32'({pending, 4'h0} | {4'h0, ready});
            end
            default: begin
              if (bankHit) begin
                next_cur.datOut = bankRead(cur.bank[bankSel], reg8[4:0]);
                if (wrLo) begin
                  next_cur.bank[bankSel] = bankWrite(cur.bank[bankSel], reg8[4:0],
                                                     wb_dat_i[7:0]);
                end
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // banked field access
  // ----------------------------------------------------------------
  function automatic logic [31:0] bankRead(input abp_bank_t b, input logic [4:0] f);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (f)
      `ABP_B_RUN:     r = 32'(b.run);
      `ABP_B_INTV_LO: r = {24'h0, b.interval[7:0]};
      `ABP_B_INTV_HI: r = {24'h0, b.interval[15:8]};
      `ABP_B_WINDOW:  r = {24'h0, b.lastCol, b.firstCol};
      `ABP_B_OFFSET:  r = {24'h0, b.offset};
      `ABP_B_WORDLEN: r = {27'h0, b.wordLen};
      `ABP_B_PACK:    r = {31'h0, b.packPort};
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic abp_bank_t bankWrite(input abp_bank_t b, input logic [4:0] f,
                                          input logic [7:0] d);
    abp_bank_t r;
    r = b;
    case (f)
      `ABP_B_RUN:     r.run            = d[`ABP_NCH-1:0];
      `ABP_B_INTV_LO: r.interval[7:0]  = d;
      `ABP_B_INTV_HI: r.interval[15:8] = d;
      `ABP_B_WINDOW:  {r.lastCol, r.firstCol} = d;
      `ABP_B_OFFSET:  r.offset         = d;
      `ABP_B_WORDLEN: r.wordLen        = d[4:0];
      `ABP_B_PACK:    r.packPort       = d[0];
      default:        r = b;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur                   <= '0;
      cur.devNum            <= `ABP_DEV_RESET;
      cur.frameCtl          <= {`ABP_FC_RESET, `ABP_FC_RESET};
      cur.bank[0].interval  <= `ABP_INTV_RESET;
      cur.bank[1].interval  <= `ABP_INTV_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign wb_dat_o    = cur.datOut;
  assign wb_ack_o    = cur.ack;
  assign wb_err_o    = cur.err;
  assign linkDataOut = cur.linkOut;
  assign linkDataOe  = cur.linkOe;
  assign pbReq       = cur.pbReq;
  assign pbWe        = cur.pbWe;
  assign pbAddr      = cur.pbAddr;
  assign pbWdata     = cur.pbWdata;
endmodule

// >>> abp_port_top_properties.sv
// Purpose: concurrent checks on the bus, bridge and link pins of the port block
// Assumes: device number stays 0, one core_clk domain
// Notes:   bound to abp_port_top after the module
`timescale 1ns/100ps
module abp_port_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [19:0] wb_adr_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        linkDataOe,
  input wire logic        pbReq,
  input wire logic [14:0] pbAddr,
  input wire logic        pbDone
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence pagedTaken;
    taken ##0 (wb_adr_i[15] && wb_adr_i[19:16] == 4'h0);
  endsequence
  a_answer_next: assert property (taken |=> wb_ack_o || wb_err_o)
    else $error("no answer one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_busy: assert property (pagedTaken ##0 pbReq |=> wb_err_o && !wb_ack_o)
    else $error("paged access while bridge busy not refused");
  a_err_cause: assert property (wb_err_o |-> $past(pbReq) && $past(wb_adr_i[15]))
    else $error("error answer without busy paged access");
  a_page_split: assert property (pagedTaken ##0 !pbReq |=>
    pbReq && pbAddr == $past(wb_adr_i[14:0])) else $error("paged address not split");
  a_local_quiet: assert property (taken ##0 !wb_adr_i[15] ##0 !pbReq |=> !pbReq)
    else $error("local access started a bridge transfer");
  a_bridge_hold: assert property (pbReq && !pbDone |=> pbReq && $stable(pbAddr))
    else $error("bridge request dropped or changed early");
  a_bridge_end: assert property (pbReq && pbDone |=> !pbReq)
    else $error("bridge request not ended by done");
  a_reset_idle: assert property ($rose(rstn) |-> (!linkDataOe && !pbReq) [*2])
    else $error("drive after reset release");
endmodule

bind abp_port_top abp_port_checker u_chk (.core_clk(core_clk), .rstn(rstn),
  .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .linkDataOe(linkDataOe), .pbReq(pbReq), .pbAddr(pbAddr),
  .pbDone(pbDone));

// >>> abp_link_master.sv
// Purpose: link-side master model making the bus clock and frame marks
// Assumes: bus clock runs free, one bit slot per clock edge
// Notes:   frames are ROWS by COLS slots, frameStart high through slot 0
`timescale 1ns/100ps
module abp_link_master #(
  parameter int ROWS = 4,
  parameter int COLS = 16
) (
  output logic linkClk,
  output logic frameStart
);
  int slot;
  initial begin
    linkClk = 1'b0;
    frameStart = 1'b0;
    slot = 1;
    #13;
    forever begin
      #80;
      linkClk = ~linkClk;
      slot = (slot + 1) % (ROWS * COLS);
      frameStart = (slot == 0);
    end
  end
endmodule

// >>> abp_port_top_tb.sv
// Purpose: self-checking bench for abp_port_top
// Assumes: device number 0, frames of 4 rows by 16 columns
// Notes:   payload checked by counting driven core cycles over four frames and by the bits shifted in
`timescale 1ns/100ps
`include "abp_cfg.svh"
module abp_port_top_tb;
  logic                          core_clk, rstn, wbWe, wbCyc, wbStb, wbAck, wbErr, e;
  logic                          linkClk, frameStart, linkDataOut, linkDataOe;
  logic                          pbReq, pbWe, pbDone;
  logic [19:0]                   wbAdr;
  logic [31:0]                   wbDatI, wbDatO, q;
  logic [3:0]                    wbSel;
  logic [14:0]                   pbAddr;
  logic [7:0]                    pbWdata, base, seen;
  logic [`ABP_NCH*`ABP_SMPW-1:0] chSamples;
  logic [`ABP_NCH-1:0]           chRunning;
  int                            mismatches, compares, seed, oeCnt, c0;

  abp_port_top DUT (.core_clk(core_clk), .rstn(rstn), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .linkClk(linkClk), .frameStart(frameStart),
    .linkDataOut(linkDataOut), .linkDataOe(linkDataOe), .chSamples(chSamples),
    .chRunning(chRunning), .pbReq(pbReq), .pbWe(pbWe), .pbAddr(pbAddr), .pbWdata(pbWdata),
    .pbDone(pbDone));
  abp_link_master LM (.linkClk(linkClk), .frameStart(frameStart));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // first core cycle of each driven slot shifts the payload bit in, MSB first
  always @(posedge core_clk) begin
    oeCnt <= oeCnt + ((linkDataOe === 1'b1) ? 1 : 0);
    if (linkDataOe === 1'b1 && oeCnt % 4 == 0) seen <= {seen[6:0], linkDataOut};
  end

  task automatic chk(input logic [39:0] s, input logic [39:0] x);
    compares++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic acc(input logic we, input logic [19:0] a, input logic [7:0] d,
                     input logic [7:0] xq, input logic xe);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'h1;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    q = wbDatO;
    e = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    chk({7'h0, e, we ? 32'h0 : q}, {7'h0, xe, 24'h0, we ? 8'h0 : xq});
  endtask

  // waits for the next rising frame mark
  task automatic wf;
    int n;
    n = 0;
    while (frameStart === 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    while (frameStart !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 600) begin
      mismatches++;
      stop_test();
    end
  endtask

  initial begin
    seed = 32'hE13F;
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'h0;
    wbAdr = 20'h0;
    wbDatI = 32'h0;
    pbDone = 1'b0;
    chRunning = 2'b01;
    chSamples = {$random(seed), $random(seed)};
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    acc(1'b0, 20'h00000, 8'h0, 8'h0F, 1'b0);
    acc(1'b0, 20'h0000C, 8'h0, 8'h00, 1'b0);
    acc(1'b0, 20'h00044, 8'h0, 8'h40, 1'b0);
    acc(1'b0, 20'h00020, 8'h0, 8'h00, 1'b0);
    acc(1'b0, 20'h0001C, 8'h0, 8'h00, 1'b0);
    c0 = oeCnt;
    wf;
    wf;
    chk(40'(oeCnt - c0), 40'h0);
    acc(1'b1, 20'h00010, 8'h03, 8'h0, 1'b0);
    acc(1'b0, 20'h00014, 8'h0, 8'h21, 1'b0);
    chRunning <= 2'b11;
    acc(1'b0, 20'h00014, 8'h0, 8'h03, 1'b0);
    acc(1'b1, 20'h09402, 8'h5A, 8'h0, 1'b0);
    chk({16'h0, pbWe, pbWdata, pbAddr}, {16'h0, 1'b1, 8'h5A, 15'h1402});
    acc(1'b0, 20'h09403, 8'h0, 8'h0, 1'b1);
    pbDone <= 1'b1;
    @(posedge core_clk);
    acc(1'b0, 20'h09403, 8'h0, 8'h0, 1'b0);
    for (int pk = 1; pk >= 0; pk--) begin
      base = (pk == 1) ? 8'h40 : 8'h20;
      chSamples <= {$random(seed), $random(seed)};
      acc(1'b1, {12'h0, base + 8'h04}, 8'h40, 8'h0, 1'b0);
      acc(1'b1, {12'h0, base + 8'h08}, 8'h00, 8'h0, 1'b0);
      acc(1'b1, {12'h0, base + 8'h0C}, 8'h52, 8'h0, 1'b0);
      acc(1'b1, {12'h0, base + 8'h10}, 8'h08, 8'h0, 1'b0);
      acc(1'b1, {12'h0, base + 8'h14}, 8'h03, 8'h0, 1'b0);
      acc(1'b1, {12'h0, base + 8'h18}, 8'(pk), 8'h0, 1'b0);
      acc(1'b1, {12'h0, base}, 8'h03, 8'h0, 1'b0);
      acc(1'b0, {12'h0, base ^ 8'h60} + 20'hC, 8'h0, (pk == 1) ? 8'h0 : 8'h52, 1'b0);
      wf;
      // write well inside the frame, so the switch lands on the next boundary
      repeat (8) @(posedge core_clk);
      acc(1'b1, {4'hF, 8'h0, 8'(pk * 4)}, 8'h0F, 8'h0, 1'b0);
      acc(1'b0, 20'h0000C, 8'h0, (pk == 1) ? 8'h06 : 8'h03, 1'b0);
      wf;
      c0 = oeCnt;
      repeat (4) wf;
      chk(40'(oeCnt - c0), (pk == 1) ? 40'd128 : 40'd112);
      if (pk == 1) chk(40'(seen), 40'({chSamples[3:0], chSamples[35:32]}));
      else chk(40'(seen[6:0]), 40'({chSamples[3:0], chSamples[35:33]}));
      acc(1'b0, 20'h0000C, 8'h0, (pk == 1) ? 8'h05 : 8'h00, 1'b0);
    end
    stop_test();
  end
endmodule
